/* File: rtl/sism_pkg.sv */
// SCSI interrupt status/mask package: offsets, bit positions, carriers.
// Assumes byte-wide register port decoded by the top module.
package sism_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_IEN0  = 8'h40;
    localparam logic [7:0] OFF_IEN1  = 8'h41;
    localparam logic [7:0] OFF_IST0  = 8'h42;
    localparam logic [7:0] OFF_IST1  = 8'h43;
    localparam logic [7:0] OFF_CTRL  = 8'h4c;
    localparam logic [7:0] OFF_STATE = 8'h4d;
    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int BIT_MISMATCH = 7;
    localparam int BIT_DONE     = 6;
    localparam int BIT_CHOSEN   = 5;
    localparam int BIT_AGAIN    = 4;
    localparam int BIT_GROSS    = 3;
    localparam int BIT_DISC     = 2;
    localparam int BIT_BUSRST   = 1;
    localparam int BIT_PARITY   = 0;
    localparam int BIT_SELWAIT  = 2;
    localparam int BIT_FREETMR  = 1;
    localparam int BIT_HSGAP    = 0;
    localparam int CTL_PAR_EN   = 0;
    localparam int CTL_LOWLEVEL = 1;
    localparam int CTL_RSP_SEL  = 2;
    localparam int CTL_RSP_RSL  = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] ST1_MASK = 3'h7;
    localparam int OFFSET_W     = 4;
    localparam int READ_GAP_CLK = 12;

    // Bus-side events, one cycle pulses or levels from the SCSI core
    typedef struct packed {
        logic                targetMode;
        logic                reqEdge;
        logic                phaseMatch;
        logic                atnLevel;
        logic                arbDone;
        logic                selDone;
        logic                selectedBy;
        logic                reselectedBy;
        logic                idMatch;
        logic                fifoRead;
        logic                fifoWrite;
        logic                fifoEmpty;
        logic                fifoFull;
        logic                ackEdge;
        logic [OFFSET_W-1:0] outstanding;
        logic                phaseChange;
        logic                xferStartNotSyncRx;
        logic                rxFifoNotEmpty;
        logic                disconnect;
        logic                discExpected;
        logic                srstLevel;
        logic                parityErr;
        logic                selTimeout;
        logic                genExpire;
        logic                hsExpire;
    } sism_evt_t;
endpackage

/* File: rtl/sism_irq_core.sv */
// SCSI interrupt status and mask block: two read-to-clear status bytes,
// two enable bytes, a control byte and a latched interrupt request.
// Assumes events are synchronous to clk; odd transmit parity is generated here from txData.
`timescale 1ns/100ps
`default_nettype none
module sism_irq_core #(
    parameter int OFFSET_W = sism_pkg::OFFSET_W
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [7:0]        regRdata,
    // Bus events
    input  wire sism_pkg::sism_evt_t evt,
    input  wire logic [OFFSET_W-1:0] maxOffset,
    // Transmit data and parity
    input  wire logic [7:0]        txData,
    output logic                   txParity,
    // Interrupt request and summary
    output logic                   irqReq,
    output logic                   scsiPending
);
    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] ien0_q, ist0_q, ctrl_q, rdata_q;
    logic [2:0] ien1_q, ist1_q;
    logic       srst_q, irq_q, par_q;
    logic [7:0] set0;
    logic [2:0] set1;
    logic       hitIen0, hitIen1, hitIst0, hitIst1, hitCtrl, hitState;
    logic       rdIst0, rdIst1, gross, discSet, srstEdge, wantIrq;
    logic [7:0] rdMux;
    logic [7:0] clr0;
    logic [2:0] clr1;
    logic       rdAny, keepIrq, irqNext;

    // ************************************************************
    // Decode
    // ************************************************************
    assign hitIen0  = regAddr == sism_pkg::OFF_IEN0;
    assign hitIen1  = regAddr == sism_pkg::OFF_IEN1;
    assign hitIst0  = regAddr == sism_pkg::OFF_IST0;
    assign hitIst1  = regAddr == sism_pkg::OFF_IST1;
    assign hitCtrl  = regAddr == sism_pkg::OFF_CTRL;
    assign hitState = regAddr == sism_pkg::OFF_STATE;
    assign rdIst0   = regRd && hitIst0;
    assign rdIst1   = regRd && hitIst1;

    // Gross error sources folded into one set term
    assign gross = (evt.fifoRead && evt.fifoEmpty) || (evt.fifoWrite && evt.fifoFull)
        || (evt.targetMode && evt.ackEdge && evt.outstanding == '0)
        || ((evt.reqEdge || evt.ackEdge) && evt.outstanding >= maxOffset
            && maxOffset != '0)
        || (!evt.targetMode && evt.phaseChange && evt.outstanding != '0)
        || (evt.xferStartNotSyncRx && evt.rxFifoNotEmpty);
    // Valid disconnects count only in low level mode; timeouts are never expected
    assign discSet = (!evt.targetMode && evt.disconnect
                      && (!evt.discExpected || ctrl_q[sism_pkg::CTL_LOWLEVEL]))
        || evt.selTimeout;
    assign srstEdge = evt.srstLevel && !srst_q;

    // Condition set vectors, independent of enables
    assign set0[sism_pkg::BIT_MISMATCH] = (!evt.targetMode && evt.reqEdge && !evt.phaseMatch)
        || (evt.targetMode && evt.atnLevel);
    assign set0[sism_pkg::BIT_DONE]   = evt.arbDone || evt.selDone;
    assign set0[sism_pkg::BIT_CHOSEN] = evt.selectedBy && evt.idMatch
        && ctrl_q[sism_pkg::CTL_RSP_SEL];
    assign set0[sism_pkg::BIT_AGAIN]  = evt.reselectedBy && evt.idMatch
        && ctrl_q[sism_pkg::CTL_RSP_RSL];
    assign set0[sism_pkg::BIT_GROSS]  = gross;
    assign set0[sism_pkg::BIT_DISC]   = discSet;
    assign set0[sism_pkg::BIT_BUSRST] = srstEdge;
    assign set0[sism_pkg::BIT_PARITY] = evt.parityErr && ctrl_q[sism_pkg::CTL_PAR_EN];
    assign set1[sism_pkg::BIT_SELWAIT] = evt.selTimeout;
    assign set1[sism_pkg::BIT_FREETMR] = evt.genExpire;
    assign set1[sism_pkg::BIT_HSGAP]   = evt.hsExpire;

    // Read mux; reserved bits read zero
    assign rdMux = hitIen0 ? ien0_q :
                   hitIen1 ? {5'h00, ien1_q} :
                   hitIst0 ? ist0_q :
                   hitIst1 ? {5'h00, ist1_q} :
                   hitCtrl ? ctrl_q :
                   hitState ? {6'h00, scsiPending, irq_q} : 8'h00;

    assign wantIrq = |(ist0_q & ien0_q) || |(ist1_q & ien1_q);

    // A status read keeps the request only for enabled bits that the read leaves behind;
    // judging by the old status would hold the request forever after its own clearing read
    assign rdAny   = rdIst0 || rdIst1;
    assign clr0    = rdIst0 ? ist0_q : 8'h00;
    assign clr1    = rdIst1 ? ist1_q : 3'h0;
    assign keepIrq = |(ist0_q & ~clr0 & ien0_q) || |(ist1_q & ~clr1 & ien1_q);
    assign irqNext = rdAny ? keepIrq : (irq_q || wantIrq);

    // ************************************************************
    // Registers
    // ************************************************************
    // Status: clear only what the read returned, new sets win
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ist0_q <= sism_pkg::RST_BYTE;
            ist1_q <= 3'h0;
        end
        else
        begin
            ist0_q <= (ist0_q & ~(rdIst0 ? ist0_q : 8'h00)) | set0;
            ist1_q <= (ist1_q & ~(rdIst1 ? ist1_q : 3'h0)) | set1;
        end
    end

    // Enables and control from software writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ien0_q <= sism_pkg::RST_BYTE;
            ien1_q <= 3'h0;
            ctrl_q <= sism_pkg::RST_BYTE;
        end
        else if (regWr)
        begin
            if (hitIen0) ien0_q <= regWdata;
            if (hitIen1) ien1_q <= regWdata[2:0] & sism_pkg::ST1_MASK;
            if (hitCtrl) ctrl_q <= regWdata;
        end
    end

    // Latched request: masking later does not drop it, only a status read does
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_q <= 1'b0;
        else
            irq_q <= irqNext;
    end

    // Edge detect history, read data, parity
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            srst_q  <= 1'b0;
            rdata_q <= 8'h00;
            par_q   <= 1'b1;
        end
        else
        begin
            srst_q  <= evt.srstLevel;
            rdata_q <= regRd ? rdMux : 8'h00;
            par_q   <= ~^txData;
        end
    end

    assign regRdata    = rdata_q;
    assign irqReq      = irq_q;
    assign txParity    = par_q;
    assign scsiPending = |ist0_q || |ist1_q;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence readOfSet0;
        rdIst0 && ist0_q != 8'h00;
    endsequence

    rd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        readOfSet0 ##0 (set0 == 8'h00) |=> ist0_q == 8'h00)
        else $error("status zero not cleared by read");
    rd_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        rdIst0 |=> regRdata == $past(ist0_q))
        else $error("status zero read data wrong");
    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        set1 != 3'h0 |=> (ist1_q & $past(set1)) == $past(set1))
        else $error("status one set lost");
    srst_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.srstLevel && srst_q && !rdIst0 && !ist0_q[1] |=> !ist0_q[1])
        else $error("bus reset level retriggered");
    par_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q[0] && !ist0_q[0] |=> !ist0_q[0] || $past(evt.parityErr) && $past(ctrl_q[0]))
        else $error("parity flagged while checking off");
    irq_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        irqReq && !rdIst0 && !rdIst1 |=> irqReq)
        else $error("interrupt dropped without read");
    irq_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ist1_q & ien1_q) != 3'h0 && !rdIst0 && !rdIst1 |=> irqReq)
        else $error("enabled condition raised no interrupt");
    tmo_disc_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.selTimeout |=> ist0_q[2] && ist1_q[2])
        else $error("timeout did not set both flags");
    par_gen_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> ^{txParity, $past(txData)} == 1'b1)
        else $error("transmit parity not odd");

    // ************************************************************
    // Per-condition checks
    // ************************************************************
    // Read of status one with bits set
    sequence readOfSet1;
        rdIst1 && ist1_q != 3'h0;
    endsequence

    // Initiator phase mismatch at request
    mism_init_a: assert property (@(posedge clk) disable iff (!rst_n)
        !evt.targetMode && evt.reqEdge && !evt.phaseMatch |=> ist0_q[7])
        else $error("phase mismatch not flagged");

    // Attention in target mode
    mism_atn_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.targetMode && evt.atnLevel |=> ist0_q[7])
        else $error("attention not flagged");

    // Target mode ignores phase compare
    mism_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.targetMode && !evt.atnLevel && !ist0_q[7] |=> !ist0_q[7])
        else $error("mismatch flagged in target mode");

    // Arbitration only completion
    done_arb_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.arbDone |=> ist0_q[6])
        else $error("arbitration done not flagged");

    // Selection completion
    done_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.selDone |=> ist0_q[6])
        else $error("selection done not flagged");

    // Selected with response enabled
    chosen_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.selectedBy && evt.idMatch && ctrl_q[2] |=> ist0_q[5])
        else $error("selection not flagged");

    // Selection without id or enable
    chosen_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!evt.idMatch || !ctrl_q[2]) && !ist0_q[5] |=> !ist0_q[5])
        else $error("selection flagged without response");

    // Reselected with response enabled
    again_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.reselectedBy && evt.idMatch && ctrl_q[3] |=> ist0_q[4])
        else $error("reselection not flagged");

    // Reselection without id or enable
    again_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!evt.idMatch || !ctrl_q[3]) && !ist0_q[4] |=> !ist0_q[4])
        else $error("reselection flagged without response");

    // Fifo underflow and overflow
    gross_fifo_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.fifoRead && evt.fifoEmpty || evt.fifoWrite && evt.fifoFull |=> ist0_q[3])
        else $error("fifo misuse not flagged");

    // Offset underflow in target mode
    gross_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.targetMode && evt.ackEdge && evt.outstanding == '0 |=> ist0_q[3])
        else $error("offset underflow not flagged");

    // Offset overflow past the programmed limit
    gross_ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.reqEdge && maxOffset != '0 && evt.outstanding == maxOffset |=> ist0_q[3])
        else $error("offset overflow not flagged");

    // Phase change with offset outstanding
    gross_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
        !evt.targetMode && evt.phaseChange && evt.outstanding != '0 |=> ist0_q[3])
        else $error("phase change with offset not flagged");

    // Residual receive data
    gross_resid_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.xferStartNotSyncRx && evt.rxFifoNotEmpty |=> ist0_q[3])
        else $error("residual data not flagged");

    // No disconnect flag in target mode except from a selection timeout
    disc_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.targetMode && !evt.selTimeout && !ist0_q[2] |=> !ist0_q[2])
        else $error("disconnect flagged in target mode");

    // Unexpected disconnect as initiator
    disc_unexp_a: assert property (@(posedge clk) disable iff (!rst_n)
        !evt.targetMode && evt.disconnect && !evt.discExpected |=> ist0_q[2])
        else $error("unexpected disconnect not flagged");

    // Low level mode flags every initiator disconnect
    disc_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        !evt.targetMode && evt.disconnect && ctrl_q[1] |=> ist0_q[2])
        else $error("low level disconnect not flagged");

    // Rising bus reset
    busrst_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.srstLevel && !srst_q |=> ist0_q[1])
        else $error("bus reset not flagged");

    // Parity error with checking on
    par_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.parityErr && ctrl_q[0] |=> ist0_q[0])
        else $error("parity error not flagged");

    // Masked conditions still reach status
    mask_indep_a: assert property (@(posedge clk) disable iff (!rst_n)
        set0 != 8'h00 && ien0_q == 8'h00 |=> (ist0_q & $past(set0)) == $past(set0))
        else $error("masked condition missing from status");

    // Status one cleared by its read
    rd1_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        readOfSet1 ##0 (set1 == 3'h0) |=> ist1_q == 3'h0)
        else $error("status one not cleared by read");

    // Status one read data
    rd1_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        rdIst1 |=> regRdata == {5'h00, $past(ist1_q)})
        else $error("status one read data wrong");

    // Status zero stands until read
    status_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        ist0_q != 8'h00 && !rdIst0 |=> (ist0_q & $past(ist0_q)) == $past(ist0_q))
        else $error("status zero bit lost without read");

    // Selection time-out flag
    sel_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        ist1_q[2] && !rdIst1 |=> ist1_q[2])
        else $error("selection time-out flag lost");

    // General timer expiry
    free_tmr_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.genExpire |=> ist1_q[1])
        else $error("general timer expiry not flagged");

    // Handshake gap expiry
    hs_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.hsExpire |=> ist1_q[0])
        else $error("handshake gap not flagged");

    // No enabled bit, no new request
    irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        !irqReq && (ist0_q & ien0_q) == 8'h00 && (ist1_q & ien1_q) == 3'h0 |=> !irqReq)
        else $error("interrupt raised while masked");

    // Enabled status zero bit raises request
    irq_raise0_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ist0_q & ien0_q) != 8'h00 && !rdIst0 && !rdIst1 |=> irqReq)
        else $error("enabled status zero raised no interrupt");

    // Clearing read drops the request
    irq_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        irqReq && rdIst0 && (ist1_q & ien1_q) == 3'h0 |=> !irqReq)
        else $error("interrupt not cleared by status read");
endmodule
`default_nettype wire

/* File: sim/sism_bus_model.sv */
// Bus-side event source standing in for the initiators and targets on the SCSI bus.
// Assumes the bench calls fire() from its main sequence, one event at a time.
`timescale 1ns/100ps
`default_nettype none
module sism_bus_model (
    // Clock
    input  wire logic               clk,
    // Event carrier toward the core
    output var sism_pkg::sism_evt_t evt
);
    // ************************************************************
    // Event driver
    // ************************************************************
    // Quiet bus between events: no edges, no levels
    initial evt = '0;

    // Hold one event for n edges, then go quiet so no stale level lingers
    task automatic fire(input sism_pkg::sism_evt_t e, input int n);
        @(posedge clk) evt <= e;
        repeat (n - 1) @(posedge clk);
        @(posedge clk) evt <= '0;
    endtask
endmodule
`default_nettype wire

/* File: sim/scsi_interrupt_status_mask_test.sv */
// Self-checking bench for the SCSI interrupt status and mask core.
// Assumes the core and the bus event model; registers are reached over the plain port.
`timescale 1ns/100ps
`default_nettype none
module scsi_interrupt_status_mask_test;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic                clk;
    logic                rst_n;
    logic [7:0]          regAddr;
    logic [7:0]          regWdata;
    logic                regWr;
    logic                regRd;
    logic [7:0]          regRdata;
    logic [3:0]          maxOffset;
    logic [7:0]          txData;
    logic                txParity;
    logic                irqReq;
    logic                scsiPending;
    wire sism_pkg::sism_evt_t evt;
    int                  failCount = 0;
    int                  compares = 0;

    sism_irq_core sism_irq_core_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .evt(evt), .maxOffset(maxOffset),
        .txData(txData), .txParity(txParity), .irqReq(irqReq), .scsiPending(scsiPending));
    sism_bus_model sism_bus_model_inst (.clk(clk), .evt(evt));

    // 50 MHz clock
    always #10 clk = ~clk;

    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failCount++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
    endtask

    // Gap after each read keeps status reads far enough apart to clear cleanly
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        #1;
        check("regRdata", regRdata, x);
        repeat (sism_pkg::READ_GAP_CLK) @(posedge clk);
    endtask

    // One event, then both status bytes; the reads also clear them for the next case
    task automatic ev(input sism_pkg::sism_evt_t e, input logic [7:0] x0, input logic [7:0] x1);
        sism_bus_model_inst.fire(e, 1);
        rd(sism_pkg::OFF_IST0, x0);
        rd(sism_pkg::OFF_IST1, x1);
    endtask

    task automatic summarize;
        if (failCount == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial
    begin
        clk = 1'h0;
        rst_n = 1'h0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'h0;
        regRd = 1'h0;
        maxOffset = 4'h0;
        txData = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rd(sism_pkg::OFF_IST0, 8'h00);
        rd(sism_pkg::OFF_IST1, 8'h00);
        rd(sism_pkg::OFF_IEN0, 8'h00);
        rd(8'h55, 8'h00);
        wr(sism_pkg::OFF_IST0, 8'hff);
        rd(sism_pkg::OFF_IST0, 8'h00);
        wr(sism_pkg::OFF_IEN1, 8'h05);
        rd(sism_pkg::OFF_IEN1, 8'h05);
        wr(sism_pkg::OFF_IEN1, 8'h00);
        // Event table; enables stay clear, so status shows regardless of masks
        ev('{targetMode: 1'h1, atnLevel: 1'h1, default: '0}, 8'h80, 8'h00);
        ev('{reqEdge: 1'h1, default: '0}, 8'h80, 8'h00);
        ev('{arbDone: 1'h1, default: '0}, 8'h40, 8'h00);
        ev('{selectedBy: 1'h1, idMatch: 1'h1, default: '0}, 8'h00, 8'h00);
        wr(sism_pkg::OFF_CTRL, 8'h04);
        ev('{selectedBy: 1'h1, default: '0}, 8'h00, 8'h00);
        ev('{selectedBy: 1'h1, idMatch: 1'h1, default: '0}, 8'h20, 8'h00);
        wr(sism_pkg::OFF_CTRL, 8'h08);
        ev('{reselectedBy: 1'h1, idMatch: 1'h1, default: '0}, 8'h10, 8'h00);
        ev('{fifoRead: 1'h1, fifoEmpty: 1'h1, default: '0}, 8'h08, 8'h00);
        ev('{targetMode: 1'h1, ackEdge: 1'h1, default: '0}, 8'h08, 8'h00);
        maxOffset <= 4'h2;
        ev('{reqEdge: 1'h1, phaseMatch: 1'h1, outstanding: 4'h2, default: '0}, 8'h08, 8'h00);
        ev('{phaseChange: 1'h1, outstanding: 4'h1, default: '0}, 8'h08, 8'h00);
        ev('{xferStartNotSyncRx: 1'h1, rxFifoNotEmpty: 1'h1, default: '0}, 8'h08, 8'h00);
        ev('{disconnect: 1'h1, default: '0}, 8'h04, 8'h00);
        ev('{disconnect: 1'h1, discExpected: 1'h1, default: '0}, 8'h00, 8'h00);
        wr(sism_pkg::OFF_CTRL, 8'h02);
        ev('{disconnect: 1'h1, discExpected: 1'h1, default: '0}, 8'h04, 8'h00);
        ev('{selTimeout: 1'h1, default: '0}, 8'h04, 8'h04);
        ev('{genExpire: 1'h1, default: '0}, 8'h00, 8'h02);
        ev('{hsExpire: 1'h1, default: '0}, 8'h00, 8'h01);
        wr(sism_pkg::OFF_CTRL, 8'h00);
        ev('{parityErr: 1'h1, default: '0}, 8'h00, 8'h00);
        wr(sism_pkg::OFF_CTRL, 8'h01);
        ev('{parityErr: 1'h1, default: '0}, 8'h01, 8'h00);
        // Long reset level: one event only, a second read finds nothing
        fork
            sism_bus_model_inst.fire('{srstLevel: 1'h1, default: '0}, 40);
            begin
                repeat (3) @(posedge clk);
                rd(sism_pkg::OFF_IST0, 8'h02);
                rd(sism_pkg::OFF_IST0, 8'h00);
            end
        join
        // Masked condition, then enabled, then cleared by the status read
        sism_bus_model_inst.fire('{fifoWrite: 1'h1, fifoFull: 1'h1, default: '0}, 1);
        repeat (3) @(posedge clk);
        #1;
        check("irqReq", {7'h00, irqReq}, 8'h00);
        check("scsiPending", {7'h00, scsiPending}, 8'h01);
        wr(sism_pkg::OFF_IEN0, 8'h08);
        repeat (2) @(posedge clk);
        #1;
        check("irqReq", {7'h00, irqReq}, 8'h01);
        rd(sism_pkg::OFF_IST0, 8'h08);
        check("irqReq", {7'h00, irqReq}, 8'h00);
        // Enabled status one bit seen through the state byte, then cleared
        wr(sism_pkg::OFF_IEN1, 8'h01);
        sism_bus_model_inst.fire('{hsExpire: 1'h1, default: '0}, 1);
        rd(sism_pkg::OFF_STATE, 8'h03);
        rd(sism_pkg::OFF_IST1, 8'h01);
        rd(sism_pkg::OFF_STATE, 8'h00);
        // Send parity follows the data even with checking off
        wr(sism_pkg::OFF_CTRL, 8'h00);
        txData <= 8'h01;
        repeat (2) @(posedge clk);
        #1;
        check("txParity", {7'h00, txParity}, 8'h00);
        @(posedge clk);
        txData <= 8'h03;
        repeat (2) @(posedge clk);
        #1;
        check("txParity", {7'h00, txParity}, 8'h01);
        summarize();
    end

    // Watchdog: the sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failCount++;
        summarize();
    end
endmodule
`default_nettype wire
